// >>> mpp_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mpp_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic prog_en,
   input wire logic dev_o,
   input wire logic dev_oe,
   input wire logic ctrl_o,
   input wire logic ctrl_oe,
   input wire logic shared_output_line
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // ownership of the shared line
   // device lags prog_en by two sync flops plus its output flop
   a_pin_release: assert property ($rose(prog_en) |-> ##4 !dev_oe)
      else $error("device still drives line in programming");
   a_ctrl_quiet: assert property (!prog_en |-> !ctrl_oe)
      else $error("controller drives line outside programming");
   a_resume_drive: assert property (
      $fell(prog_en) |-> ##[1:4] dev_oe)
      else $error("device did not resume measurement drive");
   a_no_clash: assert property (
      ctrl_oe && $past(ctrl_oe, 4) |-> !dev_oe)
      else $error("both ends drive the line");
   // ==========================================================
   // coding on the wire; half bit is never under 8 cycles here
   a_lead_low: assert property ($rose(ctrl_oe) |-> !ctrl_o [*8])
      else $error("lead-in not held low");
   a_ctrl_rate: assert property (
      ctrl_oe && $changed(ctrl_o) |=> $stable(ctrl_o) [*8])
      else $error("controller edge inside half bit");
   a_dev_rate: assert property (
      prog_en && dev_oe && $changed(dev_o) |=> $stable(dev_o) [*8])
      else $error("device edge inside half bit");
   a_fall_hold: assert property (
      prog_en && dev_oe && $fell(dev_o) |=> dev_oe [*8])
      else $error("device released right after falling edge");
endmodule : mpp_chk
`default_nettype wire

// >>> mpp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module mpp_ctrl #(
   parameter int TM_CYC = mpp_pkg::TM_CYC,
   parameter int ACC_CYC = mpp_pkg::ACC_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   mpp_if.ctrl link,
   input wire logic [15:0] half_period,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_rw,
   input wire logic [3:0] cmd_cs,
   input wire logic [1:0] cmd_fs,
   input wire logic [6:0] cmd_addr,
   input wire logic [31:0] cmd_data,
   output logic rsp_valid,
   output logic rsp_ok,
   output logic [31:0] rsp_data,
   output logic ee_done,
   output logic acc_window
);
   typedef enum logic [6:0] {
      C_IDLE = 7'h01,
      C_LEAD = 7'h02,
      C_FRAME = 7'h04,
      C_REPLY = 7'h08,
      C_RX = 7'h10,
      C_EEWAIT = 7'h20,
      C_END = 7'h40
   } mpp_cstate_e;

   localparam int CW = mpp_pkg::CNT_W;

   // ==========================================================
   // line synchroniser
   logic line_s1, line_s2, line_s3;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_s1 <= 1'b1;
         line_s2 <= 1'b1;
         line_s3 <= 1'b1;
      end else begin
         line_s1 <= link.shared_output_line;
         line_s2 <= line_s1;
         line_s3 <= line_s2;
      end
   end

   // ==========================================================
   // state
   mpp_cstate_e state, next_state;
   logic [CW-1:0] cnt, next_cnt, acc, next_acc;
   logic [6:0] hn, next_hn;
   logic [5:0] nbit, next_nbit;
   logic [50:0] fsh, next_fsh;
   logic [35:0] rsh, next_rsh, rvec;
   logic [CW-1:0] tgt, next_tgt;
   logic nv, next_nv, rw, next_rw;
   logic next_rsp_valid, next_rsp_ok, next_ee_done;
   logic [31:0] next_rsp_data;
   logic [13:0] hdr;
   logic [2:0] fcrc;
   logic [CW-1:0] half;

   assign half = CW'(half_period);
   assign hdr = {cmd_rw, cmd_cs, cmd_fs, cmd_addr};
   // crc over header and data, sync excluded
   assign fcrc = mpp_pkg::crc_calc({hdr, cmd_rw ? 32'h0 : cmd_data},
                                   cmd_rw ? mpp_pkg::HDR_W :
                                   mpp_pkg::HDR_W + mpp_pkg::DATA_W);
   assign rvec = {rsh[34:0], line_s2};
   assign cmd_ready = (state == C_IDLE);
   // window for the unlock code after reset
   assign acc_window = (acc < CW'(ACC_CYC));

   always_comb begin
      next_state = state;
      next_cnt = cnt + 1'b1;
      next_acc = acc_window ? acc + 1'b1 : acc;
      next_hn = hn;
      next_nbit = nbit;
      next_fsh = fsh;
      next_rsh = rsh;
      next_tgt = tgt;
      next_nv = nv;
      next_rw = rw;
      next_rsp_valid = 1'b0;
      next_rsp_ok = rsp_ok;
      next_rsp_data = rsp_data;
      next_ee_done = 1'b0;
      unique case (state)
         C_IDLE: begin
            next_cnt = '0;
            if (cmd_valid) begin
               // read frame omits the data field
               next_fsh = cmd_rw ? {2'b00, hdr, fcrc, 32'h0} :
                          {2'b00, hdr, cmd_data, fcrc};
               next_nbit = cmd_rw ? 6'(2 + mpp_pkg::RD_LEN) :
                           6'(2 + mpp_pkg::WR_LEN);
               next_rw = cmd_rw;
               next_nv = !cmd_rw && (cmd_addr < mpp_pkg::SHADOW_BASE);
               next_state = C_LEAD;
            end
         end
         C_LEAD: begin
            // low for two bit periods at least
            // first edge no sooner than start delay
            if ((cnt >= CW'(TM_CYC - 1)) &&
                (cnt >= CW'(half << 2))) begin
               next_cnt = '0;
               next_hn = '0;
               next_state = C_FRAME;
            end
         end
         C_FRAME: begin
            if (cnt >= half - 1'b1) begin
               next_cnt = '0;
               next_hn = hn + 1'b1;
               if (hn[0]) begin
                  next_fsh = {fsh[49:0], 1'b0};
                  next_nbit = nbit - 1'b1;
                  if (nbit == 6'h01) begin
                     next_state = rw ? C_REPLY :
                                  (nv ? C_EEWAIT : C_END);
                  end
               end
            end
         end
         C_REPLY: begin
            // stay quiet until the reply is over
            // skip the pull-up edge while the line changes hands
            if (line_s2 && !line_s3 && (cnt > half)) begin
               next_cnt = '0;
               next_tgt = half + (half >> 1);
               next_nbit = '0;
               next_state = C_RX;
            end else if (cnt > CW'(half << 5)) begin
               next_rsp_valid = 1'b1;
               next_rsp_ok = 1'b0;
               next_state = C_END;
            end
         end
         C_RX: begin
            // sample first half of each bit: its level is the bit
            if (cnt >= tgt - 1'b1) begin
               next_cnt = '0;
               next_tgt = half << 1;
               next_rsh = rvec;
               next_nbit = nbit + 1'b1;
               if (32'(nbit) == mpp_pkg::RPL_LEN - 2) begin
                  next_rsp_valid = 1'b1;
                  next_rsp_data = rvec[34:3];
                  next_rsp_ok = !rvec[35] && (rvec[2:0] ==
                     mpp_pkg::crc_calc({rvec[34:3], 14'h0000},
                                       mpp_pkg::DATA_W));
                  next_state = C_END;
               end
            end
         end
         C_EEWAIT: begin
            if ((nbit == 6'h00) && !line_s2 && line_s3) begin
               next_ee_done = 1'b1;
               next_cnt = '0;
               next_nbit = 6'h01;
            end else if ((nbit != 6'h00) && (cnt >= half)) begin
               // keep programming up for half a bit period after the device's falling edge
               next_cnt = '0;
               next_state = C_END;
            end
         end
         C_END: begin
            if (cnt >= CW'(half << 2)) begin
               next_state = C_IDLE;
            end
         end
         default: next_state = C_IDLE;
      endcase
   end

   // registers of the controller end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= C_IDLE;
         cnt <= '0;
         acc <= '0;
         hn <= '0;
         nbit <= '0;
         fsh <= '0;
         rsh <= '0;
         tgt <= '0;
         nv <= 1'b0;
         rw <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_ok <= 1'b0;
         rsp_data <= '0;
         ee_done <= 1'b0;
         link.prog_en <= 1'b0;
         link.ctrl_o <= 1'b0;
         link.ctrl_oe <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         acc <= next_acc;
         hn <= next_hn;
         nbit <= next_nbit;
         fsh <= next_fsh;
         rsh <= next_rsh;
         tgt <= next_tgt;
         nv <= next_nv;
         rw <= next_rw;
         rsp_valid <= next_rsp_valid;
         rsp_ok <= next_rsp_ok;
         rsp_data <= next_rsp_data;
         ee_done <= next_ee_done;
         link.prog_en <= (next_state != C_IDLE) && (next_state != C_END);
         // first half is the bit, second its inverse
         link.ctrl_oe <= (next_state == C_LEAD) || (next_state == C_FRAME);
         link.ctrl_o <= (next_state == C_FRAME) &&
                        (next_hn[0] ? ~next_fsh[50] : next_fsh[50]);
      end
   end
endmodule : mpp_ctrl
`default_nettype wire

// >>> mpp_device.sv
`timescale 1ns/10ps
`default_nettype none
module mpp_device #(
   parameter int TW_CYC = mpp_pkg::TW_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   mpp_if.dev link,
   input wire logic [1:0] die_addr,
   input wire logic meas_level,
   output logic mem_we,
   output logic mem_rd,
   output logic [6:0] mem_addr,
   output logic [1:0] mem_region,
   output logic [31:0] mem_wdata,
   output logic [31:0] mem_wmask,
   input wire logic [31:0] mem_rdata,
   output logic store_busy
);
   typedef enum logic [7:0] {
      D_IDLE = 8'h01,
      D_SYNC = 8'h02,
      D_BITS = 8'h04,
      D_EXEC = 8'h08,
      D_RDWAIT = 8'h10,
      D_TX = 8'h20,
      D_STORE = 8'h40,
      D_DONE = 8'h80
   } mpp_dstate_e;

   localparam int TX_LAST = 2 * (mpp_pkg::LEAD_BITS + mpp_pkg::RPL_LEN) - 1;
   localparam int CW = mpp_pkg::CNT_W;

   // ==========================================================
   // pin synchronisers
   logic prog_s1, prog_s2, line_s1, line_s2, line_s3;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_s1 <= 1'b0;
         prog_s2 <= 1'b0;
         line_s1 <= 1'b1;
         line_s2 <= 1'b1;
         line_s3 <= 1'b1;
      end else begin
         prog_s1 <= link.prog_en;
         prog_s2 <= prog_s1;
         line_s1 <= link.shared_output_line;
         line_s2 <= line_s1;
         line_s3 <= line_s2;
      end
   end

   logic rise, fall;
   assign rise = line_s2 & ~line_s3;
   assign fall = ~line_s2 & line_s3;

   // ==========================================================
   // state
   mpp_dstate_e state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic [15:0] tbit, next_tbit;
   logic [5:0] bitn, next_bitn;
   logic [6:0] txh, next_txh;
   logic [48:0] sh, next_sh;
   logic [mpp_pkg::RPL_LEN-1:0] txsh, next_txsh;
   logic [2:0] crc, next_crc;
   logic rw, next_rw;
   logic next_line_o, next_line_oe;
   logic next_we, next_rd, next_busy;
   logic [6:0] next_addr;
   logic [1:0] next_region;
   logic [31:0] next_wdata, next_wmask;

   // frame fields; header sits higher when a data field follows
   logic [13:0] hdr;
   logic [3:0] cs;
   logic [1:0] fs;
   logic [6:0] addr;
   logic [31:0] rdmask;
   logic sel, bit_v, len_rd;
   logic [15:0] three_q, tmo, hp;
   assign hdr = rw ? sh[16:3] : sh[48:35];
   assign cs = hdr[12:9];
   assign fs = hdr[8:7];
   assign addr = hdr[6:0];
   assign three_q = (tbit >> 1) + (tbit >> 2);
   assign tmo = tbit + (tbit >> 1);
   assign hp = tbit >> 1;
   assign rdmask = mpp_pkg::field_mask(fs) & mem_rdata;
   assign sel = (cs == mpp_pkg::CS_NONE) || (cs == mpp_pkg::CS_ALL) ||
                cs[die_addr];

   always_comb begin
      next_state = state;
      next_cnt = cnt + 1'b1;
      next_tbit = tbit;
      next_bitn = bitn;
      next_txh = txh;
      next_sh = sh;
      next_txsh = txsh;
      next_crc = crc;
      next_rw = rw;
      next_we = 1'b0;
      next_rd = 1'b0;
      next_addr = mem_addr;
      next_region = mem_region;
      next_wdata = mem_wdata;
      next_wmask = mem_wmask;
      bit_v = fall;
      len_rd = (bitn == 6'h00) ? bit_v : rw;
      unique case (state)
         D_IDLE: begin
            next_cnt = '0;
            // first rising edge is mid of sync bit
            if (rise) begin
               next_state = D_SYNC;
            end
         end
         D_SYNC: begin
            // bit period from two sync edges
            if (rise) begin
               // cnt starts one cycle after the first sync edge
               next_tbit = cnt[15:0] + 16'h0001;
               next_cnt = '0;
               next_bitn = '0;
               // crc starts after the sync pair
               next_crc = mpp_pkg::CRC_SEED;
               next_state = D_BITS;
            end else if (cnt[15:0] == mpp_pkg::SYNC_TMO) begin
               next_state = D_IDLE;
            end
         end
         D_BITS: begin
            if ((rise || fall) && (cnt[15:0] > three_q)) begin
               next_cnt = '0;
               next_sh = {sh[47:0], bit_v};
               if (bitn == 6'h00) begin
                  next_rw = bit_v;
               end
               // read frames carry no data field
               if (32'(bitn) < (len_rd ? mpp_pkg::RD_LEN :
                                mpp_pkg::WR_LEN) - mpp_pkg::CRC_W) begin
                  next_crc = mpp_pkg::crc_step(crc, bit_v);
               end
               next_bitn = bitn + 1'b1;
               if (32'(bitn) == (len_rd ? mpp_pkg::RD_LEN :
                                 mpp_pkg::WR_LEN) - 1) begin
                  next_state = D_EXEC;
               end
            end else if (cnt[15:0] > tmo) begin
               next_state = D_IDLE;
            end
         end
         D_EXEC: begin
            next_state = D_IDLE;
            next_addr = addr;
            if (addr < mpp_pkg::SHADOW_BASE) begin
               next_region = mpp_pkg::MPP_REG_NV;
            end else if (addr < mpp_pkg::VOL_BASE) begin
               next_region = mpp_pkg::MPP_REG_SHADOW;
            end else begin
               next_region = mpp_pkg::MPP_REG_VOL;
            end
            // drop bad crc, foreign die or unused field
            if ((crc == sh[2:0]) && sel &&
                (mpp_pkg::field_mask(fs) != 32'h00000000)) begin
               if (rw == mpp_pkg::DIR_READ) begin
                  next_rd = 1'b1;
                  next_state = D_RDWAIT;
               end else begin
                  // 32-bit data word, ecc bits included
                  next_wdata = sh[34:3];
                  // bits outside the field stay untouched
                  next_wmask = mpp_pkg::field_mask(fs);
                  next_we = 1'b1;
                  next_cnt = '0;
                  if (addr < mpp_pkg::SHADOW_BASE) begin
                     next_state = D_STORE;
                  end
               end
            end
         end
         D_RDWAIT: begin
            // read returns the selected field only
            // reply crc over the data word
            next_txsh = {2'b00, rdmask,
                         mpp_pkg::crc_calc({rdmask, 14'h0000},
                                           mpp_pkg::DATA_W)};
            next_cnt = '0;
            next_txh = '0;
            next_state = D_TX;
         end
         D_TX: begin
            // reply half bits at measured rate
            if (cnt[15:0] >= hp - 16'h0001) begin
               next_cnt = '0;
               next_txh = txh + 1'b1;
               if (txh[0] && (32'(txh) >= 2 * mpp_pkg::LEAD_BITS)) begin
                  next_txsh = {txsh[mpp_pkg::RPL_LEN-2:0], 1'b0};
               end
               if (32'(txh) == TX_LAST) begin
                  next_state = D_IDLE;
               end
            end
         end
         D_STORE: begin
            if (cnt == CW'(TW_CYC - 1)) begin
               next_cnt = '0;
               next_state = D_DONE;
            end
         end
         D_DONE: begin
            if (cnt[15:0] >= tbit) begin
               next_state = D_IDLE;
            end
         end
         default: next_state = D_IDLE;
      endcase
      if (!prog_s2) begin
         next_state = D_IDLE;
      end
      next_busy = (next_state == D_STORE);
      // line drive follows the state held this cycle
      // receive while programming, drive only to answer
      // the device drives only after a command
      // first half bit stays off: the controller still sends its last half
      next_line_oe = !prog_s2 || ((state == D_TX) && (txh != 7'h00)) ||
                     ((state == D_STORE) && (cnt >= CW'(hp))) ||
                     (state == D_DONE);
      next_line_o = 1'b0;
      if (!prog_s2) begin
         next_line_o = meas_level;
      end else if (state == D_TX) begin
         // first half equals the bit, so one falls
         if (32'(txh) >= 2 * mpp_pkg::LEAD_BITS) begin
            next_line_o = txh[0] ? ~txsh[mpp_pkg::RPL_LEN-1] :
                          txsh[mpp_pkg::RPL_LEN-1];
         end
      end else if (state == D_STORE) begin
         next_line_o = 1'b1;
      end
   end

   // registers of the device end, pin synchronisers apart
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= D_IDLE;
         cnt <= '0;
         tbit <= '0;
         bitn <= '0;
         txh <= '0;
         sh <= '0;
         txsh <= '0;
         crc <= mpp_pkg::CRC_SEED;
         rw <= 1'b0;
         link.dev_o <= 1'b0;
         link.dev_oe <= 1'b0;
         mem_we <= 1'b0;
         mem_rd <= 1'b0;
         mem_addr <= '0;
         mem_region <= mpp_pkg::MPP_REG_NV;
         mem_wdata <= '0;
         mem_wmask <= '0;
         store_busy <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         tbit <= next_tbit;
         bitn <= next_bitn;
         txh <= next_txh;
         sh <= next_sh;
         txsh <= next_txsh;
         crc <= next_crc;
         rw <= next_rw;
         link.dev_o <= next_line_o;
         link.dev_oe <= next_line_oe;
         mem_we <= next_we;
         mem_rd <= next_rd;
         mem_addr <= next_addr;
         mem_region <= next_region;
         mem_wdata <= next_wdata;
         mem_wmask <= next_wmask;
         store_busy <= next_busy;
      end
   end
endmodule : mpp_device
`default_nettype wire

// >>> mpp_if.sv
`timescale 1ns/10ps
`default_nettype none
// shared supply level and output line; undriven line is pulled high
interface mpp_if;
   logic prog_en;
   logic dev_o;
   logic dev_oe;
   logic ctrl_o;
   logic ctrl_oe;
   logic shared_output_line;

   assign shared_output_line = dev_oe ? dev_o : (ctrl_oe ? ctrl_o : 1'b1);

   modport dev (input prog_en, input shared_output_line,
                output dev_o, output dev_oe);
   modport ctrl (output prog_en, input shared_output_line,
                 output ctrl_o, output ctrl_oe);
endinterface : mpp_if
`default_nettype wire

// >>> mpp_pkg.sv
// Summary of operation
// - programming level present, device releases output pin
// - controller holds line low two bits first
// - controller waits 200 us before first edge
// - supply back to normal, device drives measurement
// - eeprom write: 20 ms, then falling edge
// - mid-bit edge: falling is one, rising zero
// - device learns bit time, replies at it
// - frame opens with sync bits 00
// - direction bit: 0 write, 1 read
// - chip select per die; 0000/1111 broadcast
// - field select: whole, 11-0, 25-12, unused
// - address regions: eeprom, shadow, volatile
// - data field: 26 payload plus 6 ecc
// - read request no data; access code 32
// - 3-bit crc x^3+x+1, seed 111
// - sync bits excluded from crc
// - address and data sent msb first
// - device never starts; read gets one reply
// - controller never overlaps device reply frame
// - unlock code within 500 ms of power-on
package mpp_pkg;
   // ==========================================================
   // timing
   localparam int CLK_MHZ = 25;
   localparam int TM_US = 200;
   localparam int TM_CYC = TM_US * CLK_MHZ;
   localparam int TW_MS = 20;
   localparam int TW_CYC = TW_MS * 1000 * CLK_MHZ;
   localparam int ACC_MS = 500;
   localparam int ACC_CYC = ACC_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam logic [15:0] SYNC_TMO = 16'hFFFF;
   // ==========================================================
   // frame layout
   localparam int LEAD_BITS = 2;
   localparam int HDR_W = 14;
   localparam int DATA_W = 32;
   localparam int CRC_W = 3;
   localparam int CRC_V = 46;
   localparam int RD_LEN = HDR_W + CRC_W;
   localparam int WR_LEN = HDR_W + DATA_W + CRC_W;
   localparam int RPL_LEN = 2 + DATA_W + CRC_W;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   localparam logic [2:0] CRC_SEED = 3'h7;
   localparam logic [3:0] CS_NONE = 4'h0;
   localparam logic [3:0] CS_ALL = 4'hF;
   localparam logic [1:0] FS_ALL = 2'h0;
   localparam logic [1:0] FS_LOW = 2'h1;
   localparam logic [1:0] FS_HIGH = 2'h2;
   localparam logic [31:0] MASK_ALL = 32'hFFFFFFFF;
   localparam logic [31:0] MASK_LOW = 32'h00000FFF;
   localparam logic [31:0] MASK_HIGH = 32'h03FFF000;
   localparam logic [6:0] SHADOW_BASE = 7'h20;
   localparam logic [6:0] VOL_BASE = 7'h40;
   typedef enum logic [1:0] {
      MPP_REG_NV = 2'h0,
      MPP_REG_SHADOW = 2'h1,
      MPP_REG_VOL = 2'h2
   } mpp_region_e;

   // ==========================================================
   // crc helpers
   // serial crc step
   function automatic logic [2:0] crc_step(input logic [2:0] c,
                                           input logic b);
      logic fb;
      fb = b ^ c[2];
      return {c[1], c[0] ^ fb, fb};
   endfunction : crc_step

   // crc over the top n bits of v, msb first
   function automatic logic [2:0] crc_calc(input logic [CRC_V-1:0] v,
                                           input int n);
      logic [2:0] c;
      c = CRC_SEED;
      for (int i = CRC_V - 1; i >= 0; i--) begin
         if (i >= CRC_V - n) begin
            c = crc_step(c, v[i]);
         end
      end
      return c;
   endfunction : crc_calc

   function automatic logic [31:0] field_mask(input logic [1:0] fs);
      unique case (fs)
         FS_ALL: return MASK_ALL;
         FS_LOW: return MASK_LOW;
         FS_HIGH: return MASK_HIGH;
         default: return 32'h00000000;
      endcase
   endfunction : field_mask
endpackage : mpp_pkg

// >>> mpp_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mpp_tb;
   localparam int LIM = 40000;
   logic ref_clk, rst_n, cmd_valid, cmd_ready, cmd_rw, rsp_valid, rsp_ok;
   logic ee_done, acc_window, meas_level, mem_we, mem_rd, store_busy;
   logic [15:0] half_period;
   logic [3:0] cmd_cs, own, other;
   logic [1:0] cmd_fs, die_addr, mem_region;
   logic [6:0] cmd_addr, mem_addr;
   logic [31:0] cmd_data, rsp_data, mem_wdata, mem_wmask, mem_rdata;
   logic [31:0] mem [128];
   logic [31:0] exp_mem [128];
   logic busy_seen, ee_seen;
   int seed, we_cnt, rd_cnt, n_mismatch, check_count;
   mpp_if link ();
   mpp_device #(.TW_CYC(200)) mpp_device_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .link(link.dev), .die_addr(die_addr),
      .meas_level(meas_level), .mem_we(mem_we), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_region(mem_region), .mem_wdata(mem_wdata),
      .mem_wmask(mem_wmask), .mem_rdata(mem_rdata), .store_busy(store_busy));
   mpp_ctrl #(.TM_CYC(20), .ACC_CYC(1000)) mpp_ctrl_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .link(link.ctrl), .half_period(half_period),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rw(cmd_rw),
      .cmd_cs(cmd_cs), .cmd_fs(cmd_fs), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
      .rsp_data(rsp_data), .ee_done(ee_done), .acc_window(acc_window));
   mpp_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .prog_en(link.prog_en),
      .dev_o(link.dev_o), .dev_oe(link.dev_oe), .ctrl_o(link.ctrl_o),
      .ctrl_oe(link.ctrl_oe), .shared_output_line(link.shared_output_line));
   // ==========================================================
   // clock, memory behind the device, watchdog
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   assign mem_rdata = mem[mem_addr];
   // memory honours the write mask like the real array would
   always @(posedge ref_clk) begin
      if (mem_we === 1'b1) begin
         mem[mem_addr] <= (mem[mem_addr] & ~mem_wmask) |
                          (mem_wdata & mem_wmask);
         we_cnt++;
      end
      if (mem_rd === 1'b1) rd_cnt++;
      if (store_busy === 1'b1) busy_seen = 1'b1;
   end
   // longest run is near 100k cycles, so allow some slack
   initial begin
      repeat (130000) @(posedge ref_clk);
      n_mismatch++;
      conclude;
   end
   // ==========================================================
   // one command with its expectation from the bench model
   task automatic cmd(input logic rw, input logic [3:0] cs,
      input logic [1:0] fs, input logic [6:0] a, input logic [31:0] d);
      int n;
      int w0;
      int r0;
      logic hit;
      logic [31:0] m;
      logic [1:0] rg;
      n = 0;
      hit = (cs == 4'h0 || cs == 4'hF || cs[die_addr]) && fs != 2'h3;
      m = fs == 2'h0 ? 32'hFFFFFFFF :
          (fs == 2'h1 ? 32'h00000FFF : 32'h03FFF000);
      rg = a < 7'h20 ? 2'h0 : (a < 7'h40 ? 2'h1 : 2'h2);
      meas_level = 1'($random(seed));
      while (cmd_ready !== 1'b1 && n < LIM) begin
         @(posedge ref_clk);
         #1 n++;
      end
      repeat (4) @(posedge ref_clk);
      #1 `CHK("meas", meas_level, link.shared_output_line)
      w0 = we_cnt;
      r0 = rd_cnt;
      busy_seen = 1'b0;
      ee_seen = 1'b0;
      {cmd_rw, cmd_cs, cmd_fs, cmd_addr, cmd_data} = {rw, cs, fs, a, d};
      cmd_valid = 1'b1;
      @(posedge ref_clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1 n++;
         if (ee_done === 1'b1) ee_seen = 1'b1;
      end while (n < LIM && !(rw ? rsp_valid === 1'b1 :
         (rg == 2'h0 && hit ? ee_seen : cmd_ready === 1'b1)));
      if (rw) begin
         `CHK("ok", hit, rsp_ok)
         `CHK("rd", hit, rd_cnt != r0)
         if (hit) `CHK("rdata", exp_mem[a] & m, rsp_data)
      end else begin
         `CHK("we", hit, we_cnt != w0)
         if (hit) begin
            `CHK("addr", a, mem_addr)
            `CHK("region", rg, mem_region)
            `CHK("mask", m, mem_wmask)
            `CHK("wdata", d & m, mem_wdata & m)
            `CHK("store", rg == 2'h0, busy_seen && ee_seen)
            exp_mem[a] = (exp_mem[a] & ~m) | (d & m);
         end
      end
   endtask : cmd
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   // ==========================================================
   // main sequence
   initial begin
      seed = 32'h0980;
      {n_mismatch, check_count, we_cnt, rd_cnt} = '0;
      {rst_n, cmd_valid, cmd_rw, cmd_cs, cmd_fs, cmd_addr, cmd_data} = '0;
      meas_level = 1'b0;
      half_period = 16'h007D;
      die_addr = 2'($random(seed));
      own = 4'h1 << die_addr;
      other = 4'h1 << (die_addr + 2'h1);
      for (int i = 0; i < 128; i++) begin
         mem[i] = 32'h0;
         exp_mem[i] = 32'h0;
      end
      repeat (5) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      @(posedge ref_clk);
      #1 `CHK("window", 1'b1, acc_window)
      cmd(1'b0, own, 2'h0, 7'h45, $random(seed));
      cmd(1'b1, 4'hF, 2'h1, 7'h45, 32'h0);
      cmd(1'b0, 4'h0, 2'h2, 7'h45, $random(seed));
      cmd(1'b1, own, 2'h0, 7'h45, 32'h0);
      cmd(1'b1, other, 2'h0, 7'h45, 32'h0);
      cmd(1'b1, 4'hF, 2'h3, 7'h45, 32'h0);
      cmd(1'b0, 4'hF, 2'h0, 7'h2A, $random(seed));
      cmd(1'b0, 4'hF, 2'h0, 7'h0B, $random(seed));
      `CHK("window", 1'b0, acc_window)
      conclude;
   end
endmodule : mpp_tb
`default_nettype wire
